// >>> halt_wakeup_pkg.sv
/*
 * Constants, field layouts and types shared by the halt / wake-up / reset sequencer
 * and its wake-edge front end.
 * Assumes a single 100 MHz clock that keeps running while the core is halted.
 */
package halt_wakeup_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses on a 32-bit classic Wishbone slave)
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // control register fields
    localparam int CTRL_WDT_ENABLE_BIT = 0;
    localparam int CTRL_WDT_FREE_OSC_BIT = 1;
    localparam int CTRL_RTC_SYSCLK_BIT = 2;
    localparam int CTRL_DISPLAY_RTC_BIT = 3;
    localparam int CTRL_WIDTH = 4;
    localparam logic [3:0] CTRL_RESET = 4'h3;

    // status register fields
    localparam int STATUS_TIMEOUT_BIT = 0;
    localparam int STATUS_POWERDOWN_BIT = 1;
    localparam int STATUS_HALTED_BIT = 2;
    localparam int STATUS_RUNNING_BIT = 3;
    localparam int STATUS_CAUSE_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////
    // timing, in system clock cycles
    localparam int CLK_MHZ = 100;
    localparam int STARTUP_CYCLES = 1024;
    localparam int POWERON_EXTRA_CYCLES = 1024;
    localparam int COUNT_WIDTH = 11;
    localparam logic [10:0] STARTUP_LOAD = 11'(STARTUP_CYCLES - 1);
    localparam logic [10:0] POWERON_LOAD = 11'(POWERON_EXTRA_CYCLES - 1);
    localparam int WDT_WIDTH = 17;
    localparam int WDT_TIMEOUT_DEFAULT = 32768;

    // port widths
    localparam int PORTA_WIDTH = 8;
    localparam int INT_WIDTH = 8;
    localparam logic [7:0] PORTA_WAKE_DEFAULT = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        ST_POWERON,
        ST_RUN,
        ST_HALTED,
        ST_STARTUP
    } seq_state_t;

    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_POWERON,
        CAUSE_PIN,
        CAUSE_WDT,
        CAUSE_INT,
        CAUSE_PORT,
        CAUSE_REMOTE
    } wake_cause_t;

    typedef enum logic [2:0] {
        RESUME_NEXT,
        RESUME_VECTOR,
        RESUME_CHIP,
        RESUME_WARM,
        RESUME_POWERON
    } resume_kind_t;

endpackage : halt_wakeup_pkg

// >>> wake_edge_detect.sv
/*
 * Wake-edge front end: per-bit falling-edge detect on port A and both-edge detect
 * on the remote-control pin, all on the always-running clock.
 * Assumes its inputs are already synchronous to clk.
 */
module wake_edge_detect
    import halt_wakeup_pkg::*;
#(
    parameter logic [7:0] PORTA_WAKE_MASK = PORTA_WAKE_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins
    input wire logic [PORTA_WIDTH-1:0] portAIn,
    input wire logic remoteControlPin,
    // detected edges
    output logic portAWake,
    output logic remoteWake
);

    typedef struct packed {
        logic [PORTA_WIDTH-1:0] portPrev;
        logic remotePrev;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;
    logic [PORTA_WIDTH-1:0] bitFall;

    ////////////////////////////////////////////////////////////////////////////
    // the mask is fixed at build time, so a disabled bit costs no logic
    for (genvar i = 0; i < PORTA_WIDTH; i++) begin : g_bit
        assign bitFall[i] = PORTA_WAKE_MASK[i] & s_q.portPrev[i] & ~portAIn[i];
    end

    assign portAWake = |bitFall;
    assign remoteWake = s_q.remotePrev ^ remoteControlPin;

    always_comb begin
        s_d = s_q;
        s_d.portPrev = portAIn;
        s_d.remotePrev = remoteControlPin;
    end

    // prev values start high/idle, so a pin low (port A) or high (remote) at reset gives one edge just after it
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '{portPrev: '1, remotePrev: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

endmodule : wake_edge_detect

// >>> halt_wakeup_reset_control.sv
/*
 * Halt, wake-up and reset sequencer of an 8-bit microcontroller, with a classic
 * Wishbone register slave for its control bits and the reset-cause flags.
 * Assumes clk is the always-running clock (watchdog / real-time domain) and that
 * the core, ports and display driver act on the enables and pulses given here.
 */
// What this block does
// - halt stops the system oscillator; watchdog oscillator keeps running if selected.
// - entering halt changes no RAM or register contents.
// - halt clears the watchdog and restarts it when on its own or RTC oscillator; here only its own oscillator restarts it.
// - during halt every I/O port keeps its previous drive or sense state.
// - halt sets the power-down flag and clears the timeout flag.
// - display driver keeps running in halt when clocked by the RTC oscillator.
// - halt ends on reset pin, interrupt, port A fall, remote edge, watchdog overflow.
// - reset pin ending halt gives chip reset; watchdog overflow gives warm reset.
// - power-down flag cleared by power-up and watchdog clear, set only by halt.
// - watchdog wake sets timeout, clears only program counter and stack pointer.
// - each port A bit's wake-up is enabled by a build-time option.
// - port stimulus wake resumes at the instruction after halt.
// - interrupt wake resumes next if disabled or stack full, else vectors.
// - an interrupt already requesting at halt entry cannot wake the device.
// - every wake waits 1024 system clocks; vector entry lags by further cycles.
// - start-up delay applies at wake and power-on; power-on adds an extra delay.
// - timeout/power-down flags identify power-up, pin, and watchdog resets in both modes; pin reset in run leaves them unchanged here.
// - chip reset clears program counter, interrupts, dividers, watchdog, timers, ports, stack.
// - watchdog wake in halt is warm; other resets restore initial register values.
// - RTC crystal keeps running in halt; as system clock only execution stops.
// - watchdog overflow in normal run gives chip reset and sets timeout flag.
module halt_wakeup_reset_control
    import halt_wakeup_pkg::*;
#(
    parameter int WDT_TIMEOUT_CYCLES = WDT_TIMEOUT_DEFAULT,
    parameter logic [7:0] PORTA_WAKE_MASK = PORTA_WAKE_DEFAULT
) (
    // clock and power-up reset
    input wire logic clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core events
    input wire logic haltExec,
    input wire logic watchdogClearExec,
    input wire logic [INT_WIDTH-1:0] intRequest,
    input wire logic [INT_WIDTH-1:0] intEnable,
    input wire logic stackFull,
    // pins
    input wire logic externalClearPinN,
    input wire logic [PORTA_WIDTH-1:0] portAIn,
    input wire logic remoteControlPin,
    // clock and run control
    output logic sysOscEnable,
    output logic execEnable,
    output logic displayClockEnable,
    output logic portsHold,
    // reset and resume strobes
    output logic chipReset,
    output logic warmReset,
    output logic resumeNext,
    output logic interruptVector,
    // reset-cause flags
    output logic timeoutFlag,
    output logic powerdownFlag
);

    typedef struct packed {
        seq_state_t state;
        logic [COUNT_WIDTH-1:0] cnt;
        logic [WDT_WIDTH-1:0] wdt;
        logic [CTRL_WIDTH-1:0] ctrl;
        logic [INT_WIDTH-1:0] intBlocked;
        resume_kind_t resume;
        wake_cause_t cause;
        logic vectorPending;
        logic timeoutFlag;
        logic powerdownFlag;
        logic sysOscEnable;
        logic execEnable;
        logic displayClockEnable;
        logic portsHold;
        logic chipReset;
        logic warmReset;
        logic resumeNext;
        logic interruptVector;
        logic ack;
        logic [31:0] rdata;
    } ctl_state_t;

    localparam logic [WDT_WIDTH-1:0] WDT_LAST = WDT_WIDTH'(WDT_TIMEOUT_CYCLES - 1);

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic portAWake;
    logic remoteWake;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic regHit(input logic [7:0] adr, input logic [7:0] offset);
        regHit = (adr[7:2] == offset[7:2]);
    endfunction : regHit

    ////////////////////////////////////////////////////////////////////////////
    // wake edges

    wake_edge_detect #(
        .PORTA_WAKE_MASK(PORTA_WAKE_MASK)
    ) u_edges (
        .clk(clk),
        .reset(reset),
        .portAIn(portAIn),
        .remoteControlPin(remoteControlPin),
        .portAWake(portAWake),
        .remoteWake(remoteWake)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic pinLow;
        logic wdtCounts;
        logic wdtOverflow;
        logic [INT_WIDTH-1:0] wakeInts;
        logic busReq;
        pinLow = ~externalClearPinN;
        wdtCounts = 1'b0;
        wdtOverflow = 1'b0;
        wakeInts = intRequest & ~s_q.intBlocked;
        busReq = wb_cyc_i & wb_stb_i & ~s_q.ack;

        s_d = s_q;
        s_d.chipReset = 1'b0;
        s_d.warmReset = 1'b0;
        s_d.resumeNext = 1'b0;
        s_d.interruptVector = 1'b0;
        s_d.vectorPending = 1'b0;

        // watchdog: in halt only its own oscillator keeps it going
        if (s_q.ctrl[CTRL_WDT_ENABLE_BIT]) begin
            unique case (s_q.state)
                ST_RUN: wdtCounts = 1'b1;
                ST_HALTED: wdtCounts = s_q.ctrl[CTRL_WDT_FREE_OSC_BIT];
                default: wdtCounts = 1'b0;
            endcase
        end
        wdtOverflow = wdtCounts & (s_q.wdt == WDT_LAST);
        if (wdtCounts) begin
            s_d.wdt = wdtOverflow ? '0 : s_q.wdt + 1'b1;
        end
        if (watchdogClearExec && s_q.state == ST_RUN) begin
            s_d.wdt = '0;
            s_d.powerdownFlag = 1'b0;
        end

        unique case (s_q.state)
            ST_POWERON: begin
                // power-on delay ahead of the ordinary start-up delay
                s_d.cnt = s_q.cnt - 1'b1;
                if (s_q.cnt == '0) begin
                    s_d.state = ST_STARTUP;
                    s_d.cnt = STARTUP_LOAD;
                    s_d.resume = RESUME_POWERON;
                end
            end

            ST_RUN: begin
                if (pinLow) begin
                    // pin reset in run leaves both flags alone
                    s_d.chipReset = 1'b1;
                    s_d.execEnable = 1'b0;
                    s_d.wdt = '0;
                    s_d.cause = CAUSE_PIN;
                end else if (wdtOverflow) begin
                    s_d.chipReset = 1'b1;
                    s_d.timeoutFlag = 1'b1;
                    s_d.cause = CAUSE_WDT;
                end else if (!s_q.execEnable) begin
                    s_d.execEnable = 1'b1;
                end else if (haltExec) begin
                    // execution, the oscillator and the display clock stop unless RTC-clocked; state is kept
                    s_d.state = ST_HALTED;
                    s_d.execEnable = 1'b0;
                    s_d.portsHold = 1'b1;
                    s_d.sysOscEnable = s_q.ctrl[CTRL_RTC_SYSCLK_BIT];
                    s_d.displayClockEnable = s_q.ctrl[CTRL_DISPLAY_RTC_BIT];
                    s_d.wdt = '0;
                    s_d.powerdownFlag = 1'b1;
                    s_d.timeoutFlag = 1'b0;
                    s_d.intBlocked = intRequest;
                end
            end

            ST_HALTED: begin
                // priority: pin, watchdog, interrupt, port A, remote
                if (pinLow) begin
                    s_d.resume = RESUME_CHIP;
                    s_d.timeoutFlag = 1'b0;
                    s_d.powerdownFlag = 1'b1;
                    s_d.cause = CAUSE_PIN;
                end else if (wdtOverflow) begin
                    s_d.resume = RESUME_WARM;
                    s_d.timeoutFlag = 1'b1;
                    s_d.powerdownFlag = 1'b1;
                    s_d.cause = CAUSE_WDT;
                end else if (|wakeInts) begin
                    s_d.resume = (|(wakeInts & intEnable) && !stackFull) ? RESUME_VECTOR : RESUME_NEXT;
                    s_d.cause = CAUSE_INT;
                end else if (portAWake) begin
                    s_d.resume = RESUME_NEXT;
                    s_d.cause = CAUSE_PORT;
                end else if (remoteWake) begin
                    s_d.resume = RESUME_NEXT;
                    s_d.cause = CAUSE_REMOTE;
                end
                if (pinLow || wdtOverflow || |wakeInts || portAWake || remoteWake) begin
                    s_d.state = ST_STARTUP;
                    s_d.cnt = STARTUP_LOAD;
                    s_d.sysOscEnable = 1'b1;
                end
            end

            ST_STARTUP: begin
                // oscillator settles here; the core stays stopped throughout
                s_d.cnt = s_q.cnt - 1'b1;
                if (s_q.cnt == '0) begin
                    s_d.state = ST_RUN;
                    s_d.portsHold = 1'b0;
                    s_d.displayClockEnable = 1'b1;
                    s_d.intBlocked = '0;
                    unique case (s_q.resume)
                        RESUME_NEXT: begin
                            s_d.execEnable = 1'b1;
                            s_d.resumeNext = 1'b1;
                        end
                        RESUME_VECTOR: begin
                            s_d.execEnable = 1'b1;
                            s_d.vectorPending = 1'b1;
                        end
                        RESUME_WARM: begin
                            s_d.execEnable = 1'b1;
                            s_d.warmReset = 1'b1;
                        end
                        RESUME_CHIP, RESUME_POWERON: begin
                            s_d.chipReset = 1'b1;
                            s_d.wdt = '0;
                        end
                    endcase
                end
            end
        endcase

        // vector entry comes one cycle after execution restarts
        if (s_q.vectorPending) begin
            s_d.interruptVector = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////
        // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
        s_d.ack = busReq;
        if (busReq) begin
            s_d.rdata = '0;
            if (regHit(wb_adr_i, CTRL_OFFSET)) begin
                s_d.rdata[CTRL_WIDTH-1:0] = s_q.ctrl;
                if (wb_we_i && wb_sel_i[0]) begin
                    s_d.ctrl = wb_dat_i[CTRL_WIDTH-1:0];
                end
            end else if (regHit(wb_adr_i, STATUS_OFFSET)) begin
                s_d.rdata[STATUS_TIMEOUT_BIT] = s_q.timeoutFlag;
                s_d.rdata[STATUS_POWERDOWN_BIT] = s_q.powerdownFlag;
                s_d.rdata[STATUS_HALTED_BIT] = (s_q.state == ST_HALTED);
                s_d.rdata[STATUS_RUNNING_BIT] = s_q.execEnable;
                s_d.rdata[STATUS_CAUSE_LSB +: 3] = s_q.cause;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '{
                state: ST_POWERON,
                cnt: POWERON_LOAD,
                wdt: '0,
                ctrl: CTRL_RESET,
                intBlocked: '0,
                resume: RESUME_POWERON,
                cause: CAUSE_POWERON,
                vectorPending: 1'b0,
                timeoutFlag: 1'b0,
                powerdownFlag: 1'b0,
                sysOscEnable: 1'b1,
                execEnable: 1'b0,
                displayClockEnable: 1'b1,
                portsHold: 1'b0,
                chipReset: 1'b1,
                warmReset: 1'b0,
                resumeNext: 1'b0,
                interruptVector: 1'b0,
                ack: 1'b0,
                rdata: '0
            };
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, straight from the state register

    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign sysOscEnable = s_q.sysOscEnable;
    assign execEnable = s_q.execEnable;
    assign displayClockEnable = s_q.displayClockEnable;
    assign portsHold = s_q.portsHold;
    assign chipReset = s_q.chipReset;
    assign warmReset = s_q.warmReset;
    assign resumeNext = s_q.resumeNext;
    assign interruptVector = s_q.interruptVector;
    assign timeoutFlag = s_q.timeoutFlag;
    assign powerdownFlag = s_q.powerdownFlag;

endmodule : halt_wakeup_reset_control

// >>> halt_wakeup_monitor.sv
/* port checker for the halt, wake-up and reset sequencer.
   assumes clk runs through halt and reset is synchronous, active high. */
module halt_wakeup_monitor
    import halt_wakeup_pkg::*;
#(
    parameter int WDT_TIMEOUT_CYCLES = WDT_TIMEOUT_DEFAULT,
    parameter logic [7:0] PORTA_WAKE_MASK = PORTA_WAKE_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // core events and pin
    input wire logic haltExec,
    input wire logic watchdogClearExec,
    input wire logic externalClearPinN,
    // run control, strobes, flags
    input wire logic sysOscEnable,
    input wire logic execEnable,
    input wire logic portsHold,
    input wire logic chipReset,
    input wire logic warmReset,
    input wire logic resumeNext,
    input wire logic interruptVector,
    input wire logic timeoutFlag,
    input wire logic powerdownFlag
);
    typedef struct packed {logic [11:0] stCnt;} mon_t;
    mon_t mon_q;
    mon_t mon_d;
    // saturates so a long halt with the oscillator kept on cannot wrap it
    always_comb begin
        mon_d = mon_q;
        if (!(portsHold && sysOscEnable && !execEnable)) begin
            mon_d.stCnt = 12'h000;
        end else if (mon_q.stCnt != 12'hfff) begin
            mon_d.stCnt = mon_q.stCnt + 12'h001;
        end
    end
    always_ff @(posedge clk) begin
        mon_q <= reset ? '0 : mon_d;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_halt_enter;
        haltExec && execEnable && externalClearPinN && !portsHold && !chipReset
        |=> !execEnable && portsHold && powerdownFlag && !timeoutFlag;
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("halt entry state wrong");
    property p_pd_set;
        $rose(powerdownFlag) |-> $past(haltExec);
    endproperty
    a_pd_set: assert property (p_pd_set) else $error("power-down flag set without halt");
    property p_pd_clear;
        watchdogClearExec && !haltExec && execEnable && !portsHold |=> !powerdownFlag;
    endproperty
    a_pd_clear: assert property (p_pd_clear) else $error("power-down flag not cleared");
    property p_startup_len;
        resumeNext || warmReset |-> mon_q.stCnt >= 12'd1023;
    endproperty
    a_startup_len: assert property (p_startup_len) else $error("resumed before start-up delay");
    property p_warm;
        warmReset |-> timeoutFlag && powerdownFlag && execEnable && !chipReset;
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset state wrong");
    property p_vector;
        interruptVector |-> execEnable && $past(execEnable) && !resumeNext;
    endproperty
    a_vector: assert property (p_vector) else $error("vector entry timing wrong");
    property p_pin_run;
        !externalClearPinN && execEnable && !portsHold
        |=> chipReset && !execEnable && $stable(timeoutFlag) && $stable(powerdownFlag);
    endproperty
    a_pin_run: assert property (p_pin_run) else $error("pin reset in run wrong");
    property p_wdt_run;
        chipReset && execEnable |-> timeoutFlag;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset without timeout flag");
    property p_osc_run;
        execEnable |-> sysOscEnable;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("executing with oscillator off");
    c_vector: cover property (interruptVector);
    c_warm: cover property (warmReset);
    c_resume: cover property (resumeNext);
    c_pin_wake: cover property (chipReset && $past(portsHold));
endmodule : halt_wakeup_monitor

bind halt_wakeup_reset_control halt_wakeup_monitor #(
    .WDT_TIMEOUT_CYCLES(WDT_TIMEOUT_CYCLES),
    .PORTA_WAKE_MASK(PORTA_WAKE_MASK)
) i_halt_wakeup_monitor (.clk, .reset, .haltExec, .watchdogClearExec, .externalClearPinN,
    .sysOscEnable, .execEnable, .portsHold, .chipReset, .warmReset, .resumeNext,
    .interruptVector, .timeoutFlag, .powerdownFlag);

// >>> wake_source_model.sv
/* far side: external clear pin, port A lines and remote-control pin.
   assumes callers use its tasks just after a rising clock edge. */
module wake_source_model
    import halt_wakeup_pkg::*;
(
    // pins toward the device
    output logic externalClearPinN,
    output logic [PORTA_WIDTH-1:0] portAIn,
    output logic remoteControlPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // port A idles high as with pull-ups, so only a real fall can wake
    initial begin
        externalClearPinN = 1'b1;
        portAIn = '1;
        remoteControlPin = 1'b0;
    end
    task automatic set_pin(input logic v);
        externalClearPinN <= v;
    endtask : set_pin
    task automatic set_port(input logic [PORTA_WIDTH-1:0] v);
        portAIn <= v;
    endtask : set_port
    task automatic flip_remote();
        remoteControlPin <= ~remoteControlPin;
    endtask : flip_remote
endmodule : wake_source_model

// >>> tb_top.sv
/* self-checking bench for the halt, wake-up and reset sequencer.
   assumes the bound monitor and the wake source model beside it. */
module tb_top
    import halt_wakeup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAKE_SEEN = STARTUP_CYCLES + 2;
    logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, haltExec, watchdogClearExec;
    logic stackFull, externalClearPinN, remoteControlPin, sysOscEnable, execEnable;
    logic portsHold, chipReset, warmReset, resumeNext, interruptVector, timeoutFlag, powerdownFlag, displayClockEnable;
    logic [7:0] wb_adr_i, portAIn, intRequest, intEnable;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i, selMask;
    int errCount, nChecks, n;
    // short watchdog count keeps its scenarios brief; bit 0 of port A cannot wake
    halt_wakeup_reset_control #(.WDT_TIMEOUT_CYCLES(32), .PORTA_WAKE_MASK(8'hfe))
    i_halt_wakeup_reset_control (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .haltExec, .watchdogClearExec,
        .intRequest, .intEnable, .stackFull, .externalClearPinN, .portAIn, .remoteControlPin,
        .sysOscEnable, .execEnable, .displayClockEnable, .portsHold, .chipReset, .warmReset,
        .resumeNext, .interruptVector, .timeoutFlag, .powerdownFlag);
    wake_source_model i_wake_source_model (.externalClearPinN, .portAIn, .remoteControlPin);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= selMask;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        check("ack", wb_ack_o, 1'b1);
    endtask : bus
    task automatic wait_for(input int which, input int limit);
        logic s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            case (which)
                0: s = resumeNext;
                1: s = interruptVector;
                2: s = warmReset;
                3: s = chipReset;
                default: s = execEnable;
            endcase
        end while (s !== 1'b1 && n < limit);
        check("awaited strobe", s, 1'b1);
    endtask : wait_for
    task automatic pulse_halt();
        @(posedge clk);
        haltExec <= 1'b1;
        @(posedge clk);
        haltExec <= 1'b0;
        @(posedge clk);
        check("halt entry", {execEnable, portsHold, timeoutFlag, powerdownFlag}, 4'b0101);
    endtask : pulse_halt
    ////////////////////////////////////////////////////////////
    task automatic t_poweron();
        selMask = 4'he;
        bus(1'b1, CTRL_OFFSET, 32'h0);
        selMask = 4'hf;
        bus(1'b0, CTRL_OFFSET, 32'h0);
        check("ctrl reset", rd, {28'h0, CTRL_RESET});
        bus(1'b1, CTRL_OFFSET, 32'h0);
        bus(1'b1, 8'h08, 32'hffffffff);
        bus(1'b0, 8'h08, 32'h0);
        check("unmapped read", rd, 32'h0);
        bus(1'b1, STATUS_OFFSET, 32'hff);
        wait_for(4, 3000);
        check("power-on delay", n >= 2030, 1'b1);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        check("power-up status", rd[6:0], {CAUSE_POWERON, 4'b1000});
    endtask : t_poweron
    task automatic t_port();
        pulse_halt();
        i_wake_source_model.set_port(8'hfe);
        repeat (60) @(posedge clk);
        check("masked bit stays halted", {execEnable, portsHold, displayClockEnable}, 3'b010);
        i_wake_source_model.set_port(8'hfc);
        wait_for(0, 1200);
        check("port wake latency", n, WAKE_SEEN);
        check("port wake flags", {timeoutFlag, powerdownFlag}, 2'b01);
        i_wake_source_model.set_port(8'hff);
    endtask : t_port
    task automatic t_remote();
        pulse_halt();
        i_wake_source_model.flip_remote();
        wait_for(0, 1200);
        check("remote wake latency", n, WAKE_SEEN);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        check("remote cause", rd[6:4], CAUSE_REMOTE);
    endtask : t_remote
    task automatic t_irq();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            intEnable <= (i == 1) ? 8'h00 : 8'hff;
            stackFull <= (i == 2);
            intRequest <= 8'h01;
            pulse_halt();
            repeat (40) @(posedge clk);
            check("pending request blocked", execEnable, 1'b0);
            intRequest <= 8'h03;
            wait_for((i == 0) ? 1 : 0, 1200);
            intRequest <= 8'h00;
            stackFull <= 1'b0;
        end
    endtask : t_irq
    task automatic t_wdt_run();
        @(posedge clk);
        watchdogClearExec <= 1'b1;
        @(posedge clk);
        watchdogClearExec <= 1'b0;
        @(posedge clk);
        check("clear instruction", powerdownFlag, 1'b0);
        bus(1'b1, CTRL_OFFSET, 32'h1);
        wait_for(3, 200);
        check("run timeout", {execEnable, timeoutFlag, powerdownFlag}, 3'b110);
        bus(1'b1, CTRL_OFFSET, 32'h0);
    endtask : t_wdt_run
    task automatic t_pin_run();
        i_wake_source_model.set_pin(1'b0);
        repeat (3) @(posedge clk);
        check("pin in run", {chipReset, execEnable, timeoutFlag, powerdownFlag}, 4'b1010);
        i_wake_source_model.set_pin(1'b1);
        wait_for(4, 10);
    endtask : t_pin_run
    task automatic t_wakes();
        bus(1'b1, CTRL_OFFSET, 32'h3);
        pulse_halt();
        wait_for(2, 3000);
        check("watchdog wake", {execEnable, timeoutFlag, powerdownFlag}, 3'b111);
        bus(1'b1, CTRL_OFFSET, 32'h0);
        pulse_halt();
        i_wake_source_model.set_pin(1'b0);
        repeat (4) @(posedge clk);
        i_wake_source_model.set_pin(1'b1);
        wait_for(3, 1200);
        check("pin wake flags", {timeoutFlag, powerdownFlag}, 2'b01);
        wait_for(4, 10);
    endtask : t_wakes
    ////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, haltExec, watchdogClearExec, stackFull} = 6'h00;
        {wb_adr_i, intRequest, intEnable} = 24'h000000;
        {wb_dat_i, wb_sel_i, selMask} = {32'h0, 4'h0, 4'hf};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_poweron();
        t_port();
        t_remote();
        t_irq();
        t_wdt_run();
        t_pin_run();
        t_wakes();
        close_out();
    end
    initial begin
        #500000;
        errCount++;
        close_out();
    end
endmodule : tb_top
